// *** verilog/vbs_ctrl.sv ***
// sleep/wake, standby and cpu access control of the single-wire link
// assumes the cpu strobes and link engine events share i_clk;
// only the receive pin arrives asynchronously
`timescale 1ns/1ps

// How it works
// - halt keeps link running; sleep resumes on edge
// - stop halts link, levels held
// - sleep request, idle bus outside stop gives code 10
// - sleeping rx rising edge raises wake code 00
// - pending flag high while request outstanding
// - one request enters sleep only once
// - asleep outside stop keeps link and irqs
// - after stop wake, wait settle before receiving
// - wake bit leaves sleep outside stop, source switched
// - wake interrupt only in sleep state
// - control one command bits self clear
// - control two wake and sleep self clear
// - write busy held after tx fifo write
// - fill bits read zero during rx read
// - reception error blocks link until cleared
// - irq enable gates completion and error
// - no-crc bit disables crc use
// - source flags encode interrupt cause
// - wake irq ignores enable, masked awake
// - newer source code overwrites older one
// - sleep enable only after bus idle
module vbs_ctrl
    import vbs_pkg::*;
#(
    parameter int OSC_WAIT_BASE = OSC_BASE_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_ctl1_wr,
    input  wire logic [7:0] i_ctl1_wdata,
    input  wire logic       i_ctl2_wr,
    input  wire logic [7:0] i_ctl2_wdata,
    input  wire logic       i_tx_fifo_port_wr,
    input  wire logic [7:0] i_tx_fifo_port_wdata,
    input  wire logic       i_rx_fifo_port_rd,
    input  wire logic [7:0] i_rx_fifo_data,
    input  wire logic [1:0] i_rx_fill,
    input  wire logic       i_stop_mode,
    input  wire logic [2:0] i_osc_settle_select,
    input  wire logic       i_irq_enable_bit,
    input  wire logic       i_bus_rx_pin,
    input  wire logic       i_bus_idle,
    input  wire logic       i_rx_done,
    input  wire logic       i_rx_err,
    output logic [7:0]      o_control_reg_one,
    output logic [7:0]      o_control_reg_two,
    output logic [7:0]      o_status_reg_one,
    output logic            o_sleep_pending_flag,
    output logic            o_sleep_state,
    output logic            o_bus_irq,
    output logic            o_link_run,
    output logic            o_crc_enable,
    output logic            o_break_command,
    output logic            o_abort_command,
    output logic            o_tx_start_command,
    output logic            o_abort_receive_command,
    output logic            o_tx_push,
    output logic [7:0]      o_tx_data,
    output logic            o_rx_pop,
    output logic [7:0]      o_rx_data
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    vbs_pm_type       pm_reg, pm_next;
    logic [7:0]       c1_pend_reg, c2_pend_reg;
    logic [7:0]       ctl1_reg, ctl2_reg;
    logic             c1_act_reg, c2_act_reg;
    logic [1:0]       src_reg, src_next;
    logic             irq_reg, irq_next;
    logic             err_reg, rx_q_reg;
    logic             wbusy_reg, rbusy_reg, run_reg;
    logic [7:0]       txd_reg, rxd_reg;
    logic             push_reg, pop_reg;
    logic [3:0]       cmd_reg;
    logic             rx_s, c1_busy, c1_exp, c2_busy, c2_exp;
    logic             tx_busy, tx_exp, rd_busy, rd_exp;
    logic             osc_busy, osc_exp;
    logic [OSC_W-1:0] osc_count;
    logic             rx_rise, quiet, ev_done, ev_err, ev_sleep_en;
    logic             ev_wake, wake_cmd, sleep_cmd, errclr;

    vbs_sync2 u_rx_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async (i_bus_rx_pin),
        .o_sync  (rx_s)
    );

    // ------------------------------------------------------------
    // command windows: a second write inside one overwrites
    // ------------------------------------------------------------
    vbs_timer #(.W(TMR_W)) u_c1_win (
        .i_clk(i_clk), .i_rst(i_rst), .i_load(i_ctl1_wr),
        .i_count(TMR_W'(CMD_WINDOW_CYC)),
        .o_busy(c1_busy), .o_expire(c1_exp)
    );
    vbs_timer #(.W(TMR_W)) u_c2_win (
        .i_clk(i_clk), .i_rst(i_rst), .i_load(i_ctl2_wr),
        .i_count(TMR_W'(CMD_WINDOW_CYC)),
        .o_busy(c2_busy), .o_expire(c2_exp)
    );
    vbs_timer #(.W(TMR_W)) u_tx_win (
        .i_clk(i_clk), .i_rst(i_rst), .i_load(i_tx_fifo_port_wr),
        .i_count(TMR_W'(FIFO_BUSY_CYC)),
        .o_busy(tx_busy), .o_expire(tx_exp)
    );
    vbs_timer #(.W(TMR_W)) u_rd_win (
        .i_clk(i_clk), .i_rst(i_rst), .i_load(i_rx_fifo_port_rd),
        .i_count(TMR_W'(FIFO_BUSY_CYC)),
        .o_busy(rd_busy), .o_expire(rd_exp)
    );
    vbs_timer #(.W(OSC_W)) u_osc_win (
        .i_clk(i_clk), .i_rst(i_rst), .i_load(ev_wake && i_stop_mode),
        .i_count(osc_count),
        .o_busy(osc_busy), .o_expire(osc_exp)
    );

    // ------------------------------------------------------------
    // event decode
    // ------------------------------------------------------------
    assign osc_count = OSC_W'(OSC_WAIT_BASE) << i_osc_settle_select;
    assign rx_rise   = rx_s && !rx_q_reg;
    // stop and the settle wait block rx events, sleep enable and run, but not the wake edge
    assign quiet     = i_stop_mode || pm_reg == PM_OSC_WAIT;
    assign ev_done   = i_rx_done && !quiet && i_irq_enable_bit;
    assign ev_err    = i_rx_err && !quiet && i_irq_enable_bit;
    assign ev_sleep_en = pm_reg == PM_SLEEP_REQ && i_bus_idle && !quiet;
    assign ev_wake   = pm_reg == PM_SLEEP && rx_rise;
    assign sleep_cmd = c2_act_reg && ctl2_reg[C2_SLEEP];
    assign wake_cmd  = c2_act_reg && ctl2_reg[C2_WAKE] && !i_stop_mode;
    assign errclr    = c1_act_reg && ctl1_reg[C1_ERRCLR];

    // ------------------------------------------------------------
    // sleep state machine
    // ------------------------------------------------------------
    always_comb begin
        pm_next = pm_reg;
        case (pm_reg)
            PM_AWAKE: begin
                if (sleep_cmd) begin
                    pm_next = PM_SLEEP_REQ;
                end
            end
            PM_SLEEP_REQ: begin
                if (wake_cmd) begin
                    pm_next = PM_AWAKE;
                end else if (ev_sleep_en) begin
                    pm_next = PM_SLEEP;
                end
            end
            PM_SLEEP: begin
                if (ev_wake && i_stop_mode) begin
                    pm_next = PM_OSC_WAIT;
                end else if (ev_wake || wake_cmd) begin
                    pm_next = PM_AWAKE;
                end
            end
            PM_OSC_WAIT: begin
                if (osc_exp) begin
                    pm_next = PM_AWAKE;
                end
            end
            default: pm_next = PM_AWAKE;
        endcase
    end

    // ------------------------------------------------------------
    // interrupt source and request
    // ------------------------------------------------------------
    // later causes overwrite; error outranks simultaneous causes
    always_comb begin
        src_next = src_reg;
        irq_next = 1'b1;
        if (ev_err) begin
            src_next = SRC_ERR;
        end else if (ev_done) begin
            src_next = SRC_DONE;
        end else if (ev_sleep_en) begin
            src_next = SRC_SLEEP;
        end else if (ev_wake) begin
            src_next = SRC_WAKE;
        end else begin
            irq_next = 1'b0;
            if (wake_cmd && pm_reg == PM_SLEEP) begin
                src_next = SRC_WAKE; // switched without a request
            end
        end
    end

    // ------------------------------------------------------------
    // control registers with latch-then-act command bits
    // ------------------------------------------------------------
    // latch then act
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            c1_pend_reg <= CTL_RESET;
            c2_pend_reg <= CTL_RESET;
            ctl1_reg    <= CTL_RESET;
            ctl2_reg    <= CTL_RESET;
            c1_act_reg  <= 1'b0;
            c2_act_reg  <= 1'b0;
        end else begin
            if (i_ctl1_wr) begin
                c1_pend_reg <= i_ctl1_wdata;
            end
            if (i_ctl2_wr) begin
                c2_pend_reg <= i_ctl2_wdata;
            end
            c1_act_reg <= c1_exp;
            c2_act_reg <= c2_exp;
            if (c1_exp) begin
                ctl1_reg <= c1_pend_reg;
            end else if (c1_act_reg) begin
                ctl1_reg <= ctl1_reg & ~C1_AUTO_MASK;
            end
            if (c2_exp) begin
                ctl2_reg <= c2_pend_reg;
            end else if (c2_act_reg) begin
                ctl2_reg <= ctl2_reg & ~C2_AUTO_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // state, error latch, fifo access windows
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pm_reg    <= PM_AWAKE;
            src_reg   <= SRC_WAKE;
            irq_reg   <= 1'b0;
            err_reg   <= 1'b0;
            rx_q_reg  <= 1'b0;
            wbusy_reg <= 1'b0;
            rbusy_reg <= 1'b0;
            run_reg   <= 1'b1;
            txd_reg   <= 8'h00;
            rxd_reg   <= 8'h00;
            push_reg  <= 1'b0;
            pop_reg   <= 1'b0;
            cmd_reg   <= 4'h0;
        end else begin
            pm_reg   <= pm_next;
            src_reg  <= src_next;
            irq_reg  <= irq_next;
            rx_q_reg <= rx_s;
            // error blocks link; set wins over clear
            err_reg  <= (i_rx_err && !quiet) || (err_reg && !errclr);
            run_reg  <= !quiet && !err_reg && !(i_rx_err && !quiet);
            wbusy_reg <= i_tx_fifo_port_wr || (tx_busy && !tx_exp);
            if (i_tx_fifo_port_wr) begin
                txd_reg <= i_tx_fifo_port_wdata;
            end
            push_reg <= tx_exp;
            rbusy_reg <= i_rx_fifo_port_rd || (rd_busy && !rd_exp);
            pop_reg   <= i_rx_fifo_port_rd;
            if (rd_exp) begin
                rxd_reg <= i_rx_fifo_data;
            end
            cmd_reg <= c1_act_reg ? {ctl1_reg[C1_ABORTRX],
                                     ctl1_reg[C1_TXSTART],
                                     ctl1_reg[C1_ABORT],
                                     ctl1_reg[C1_BREAK]} : 4'h0;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // pending flag
    assign o_sleep_pending_flag = pm_reg == PM_SLEEP_REQ;
    assign o_sleep_state     = pm_reg == PM_SLEEP;
    assign o_control_reg_one = ctl1_reg;
    assign o_control_reg_two = ctl2_reg;
    assign o_status_reg_one  = {rbusy_reg ? 2'h0 : i_rx_fill,
                                src_reg, wbusy_reg, 3'h0};
    assign o_bus_irq         = irq_reg;
    assign o_link_run        = run_reg;
    assign o_crc_enable      = !ctl1_reg[C1_NOCRC];
    assign o_break_command   = cmd_reg[0];
    assign o_abort_command   = cmd_reg[1];
    assign o_tx_start_command = cmd_reg[2];
    assign o_abort_receive_command = cmd_reg[3];
    assign o_tx_push         = push_reg;
    assign o_tx_data         = txd_reg;
    assign o_rx_pop          = pop_reg;
    assign o_rx_data         = rxd_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_sleep_code: assert property (@(posedge i_clk) disable iff (i_rst)
        ev_sleep_en && !ev_err && !ev_done |=> irq_reg && src_reg == 2'h2)
        else $error("sleep enable not coded 10");
    a_wake_code: assert property (@(posedge i_clk) disable iff (i_rst)
        ev_wake && !ev_err && !ev_done |=> irq_reg && src_reg == 2'h0)
        else $error("wake request not coded 00");
    a_wake_in_sleep: assert property (@(posedge i_clk) disable iff (i_rst)
        irq_reg && src_reg == 2'h0 |-> $past(pm_reg) == PM_SLEEP)
        else $error("wake irq outside sleep");
    a_pending_held: assert property (@(posedge i_clk) disable iff (i_rst)
        sleep_cmd && pm_reg == PM_AWAKE |=> o_sleep_pending_flag)
        else $error("pending flag not raised");
    a_stop_halts: assert property (@(posedge i_clk) disable iff (i_rst)
        i_stop_mode |=> !run_reg)
        else $error("link runs in stop");
    a_err_blocks: assert property (@(posedge i_clk) disable iff (i_rst)
        err_reg |=> !run_reg)
        else $error("link runs with error latched");
    a_osc_blocks: assert property (@(posedge i_clk) disable iff (i_rst)
        pm_reg == PM_OSC_WAIT |=> !run_reg)
        else $error("link runs during settle wait");
    a_wbusy_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        i_tx_fifo_port_wr |=> wbusy_reg [*8])
        else $error("write busy dropped early");
    a_fill_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        i_rx_fifo_port_rd |=> (o_status_reg_one[7:6] == 2'h0) [*8])
        else $error("fill bits shown during read");
    a_cmd_clear: assert property (@(posedge i_clk) disable iff (i_rst)
        c1_act_reg |=> (ctl1_reg & C1_AUTO_MASK) == 8'h00)
        else $error("command bits not cleared");
    a_ie_gate: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_irq_enable_bit && !ev_sleep_en && !ev_wake |=> !irq_reg)
        else $error("irq raised while disabled");
endmodule // vbs_ctrl

// *** inc/vbs_pkg.sv ***
// package for the vehicle bus sleep/wake and host access block
// assumes a single 50 MHz clock shared by the cpu side and the link side
package vbs_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 50;
    localparam int CMD_WINDOW_NS  = 480;   // command latch window
    localparam int FIFO_BUSY_NS   = 3800;  // fifo access disable time
    // both times round down to whole cycles
    localparam int CMD_WINDOW_CYC = (CMD_WINDOW_NS * CLK_MHZ) / 1000;
    localparam int FIFO_BUSY_CYC  = (FIFO_BUSY_NS * CLK_MHZ) / 1000;
    localparam int TMR_W          = 8;
    localparam int OSC_W          = 18;
    localparam int OSC_BASE_CYC   = 1024;  // settle wait for select 0

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int C1_BREAK   = 0;
    localparam int C1_ABORT   = 2;
    localparam int C1_TXSTART = 3;
    localparam int C1_ERRCLR  = 4;
    localparam int C1_NOCRC   = 5;
    localparam int C1_ABORTRX = 7;
    localparam int C2_WAKE    = 0;
    localparam int C2_SLEEP   = 3;
    localparam int ST_WBUSY   = 3;
    localparam int ST_SRC_LO  = 4;
    localparam int ST_SRC_HI  = 5;
    localparam int ST_FILL_LO = 6;
    localparam int ST_FILL_HI = 7;

    // self-clearing command bits of each control register
    localparam logic [7:0] C1_AUTO_MASK = 8'h9D;
    localparam logic [7:0] C2_AUTO_MASK = 8'h09;
    localparam logic [7:0] CTL_RESET    = 8'h00;

    // ------------------------------------------------------------
    // interrupt source codes
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_WAKE  = 2'h0;
    localparam logic [1:0] SRC_DONE  = 2'h1;
    localparam logic [1:0] SRC_SLEEP = 2'h2;
    localparam logic [1:0] SRC_ERR   = 2'h3;

    typedef enum logic [1:0] {
        PM_AWAKE,
        PM_SLEEP_REQ,
        PM_SLEEP,
        PM_OSC_WAIT
    } vbs_pm_type;

endpackage

// *** verilog/vbs_sync2.sv ***
// two-flop synchroniser for a level arriving from a pin
// assumes the destination logic runs on i_clk
`timescale 1ns/1ps
module vbs_sync2 (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_reg;

    // ------------------------------------------------------------
    // first flop feeds only the second
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_reg <= 1'b0;
            o_sync   <= 1'b0;
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end
endmodule // vbs_sync2

// *** verilog/vbs_timer.sv ***
// reloadable down counter: busy while non-zero, flags the last cycle
// assumes load and count come from logic on the same clock
`timescale 1ns/1ps
module vbs_timer #(
    parameter int W = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_count,
    output logic              o_busy,
    output logic              o_expire
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    // a reload restarts the window, so a late write stretches it
    assign cnt_next = i_load ? i_count :
                      (o_busy ? cnt_reg - W'(1) : cnt_reg);
    assign o_busy   = (cnt_reg != '0);
    assign o_expire = (cnt_reg == W'(1)) && !i_load;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule // vbs_timer

// *** verif/vbs_link_model.sv ***
// link engine and receive fifo model facing vbs_ctrl
// assumes the bench calls its tasks right after a clock edge
`timescale 1ns/1ps
module vbs_link_model (
    input  wire logic i_clk,
    input  wire logic i_link_run,
    output logic       o_pin,
    output logic       o_idle,
    output logic       o_done,
    output logic       o_err,
    output logic [7:0] o_data,
    output logic [1:0] o_fill
);
    // ------------------------------------------------------------
    // idle bus sits low, fifo holds one fixed byte
    // ------------------------------------------------------------
    initial begin
        o_pin  = 1'b0;
        o_idle = 1'b1;
        o_done = 1'b0;
        o_err  = 1'b0;
        o_data = 8'h5A;
        o_fill = 2'h3;
    end
    // keeps the bus busy so a sleep request stays pending
    task automatic hold(input logic busy);
        o_idle = !busy;
    endtask
    // one rising edge on the pin, held long enough to pass the sync
    task automatic rise();
        o_pin = 1'b1;
        repeat (4) @(posedge i_clk);
        #1 o_pin = 1'b0;
    endtask
    // frames stay short, normal mode only
    // no result while the link is held off
    task automatic frame(input logic bad);
        o_idle = 1'b0;
        rise();
        @(posedge i_clk) #1 o_done = !bad && i_link_run;
        o_err = bad && i_link_run;
        @(posedge i_clk) #1 o_done = 1'b0;
        o_err  = 1'b0;
        o_idle = 1'b1;
    endtask
endmodule // vbs_link_model

// *** verif/tb_top.sv ***
// self-checking bench for vbs_ctrl with the link model beside it
// assumes settle base shortened to 4 cycles, inputs moved 1 ns late
`timescale 1ns/1ps
module tb_top;
    import vbs_pkg::*;
    typedef struct packed {
        logic [7:0] wd;
        logic [7:0] rg;
        logic [3:0] cmd;
    } vbs_row_type;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        c1_wr = 1'b0, c2_wr = 1'b0, tx_wr = 1'b0, rx_rd = 1'b0;
    logic        stop = 1'b0, ie = 1'b1;
    logic [7:0]  c1_wd = 8'h00, c2_wd = 8'h00, tx_wd = 8'h00;
    logic [2:0]  sel = 3'h3;
    logic [7:0]  creg1, creg2, st, txd, rxd, fdat;
    logic        pend, slp, irq, run, crc, brk, abt, txs, abrx, push, pop;
    logic        pin, idle, done, err;
    logic [1:0]  fill;
    logic [3:0]  cmd_seen = 4'h0;
    int          error_cnt = 0, total_checks = 0, irq_cnt = 0, cyc = 0, n;
    vbs_row_type rows [5] = '{'{8'hFF, 8'h62, 4'hF}, '{8'h20, 8'h20, 4'h0},
        '{8'h9D, 8'h00, 4'hF}, '{8'h04, 8'h00, 4'h2}, '{8'h00, 8'h00, 4'h0}};

    vbs_ctrl #(.OSC_WAIT_BASE(4)) dut_u (.i_clk(i_clk), .i_rst(i_rst),
        .i_ctl1_wr(c1_wr), .i_ctl1_wdata(c1_wd), .i_ctl2_wr(c2_wr),
        .i_ctl2_wdata(c2_wd), .i_tx_fifo_port_wr(tx_wr),
        .i_tx_fifo_port_wdata(tx_wd), .i_rx_fifo_port_rd(rx_rd),
        .i_rx_fifo_data(fdat), .i_rx_fill(fill), .i_stop_mode(stop),
        .i_osc_settle_select(sel), .i_irq_enable_bit(ie),
        .i_bus_rx_pin(pin), .i_bus_idle(idle), .i_rx_done(done),
        .i_rx_err(err), .o_control_reg_one(creg1),
        .o_control_reg_two(creg2), .o_status_reg_one(st),
        .o_sleep_pending_flag(pend), .o_sleep_state(slp), .o_bus_irq(irq),
        .o_link_run(run), .o_crc_enable(crc), .o_break_command(brk),
        .o_abort_command(abt), .o_tx_start_command(txs),
        .o_abort_receive_command(abrx), .o_tx_push(push), .o_tx_data(txd),
        .o_rx_pop(pop), .o_rx_data(rxd));
    vbs_link_model lm_u (.i_clk(i_clk), .i_link_run(run), .o_pin(pin),
        .o_idle(idle), .o_done(done), .o_err(err), .o_data(fdat),
        .o_fill(fill));

    // ------------------------------------------------------------
    // clock, monitors, hang guard
    // ------------------------------------------------------------
    always #10 i_clk = ~i_clk;
    // sticky command pulses and irq count, sampled on the edge
    always @(posedge i_clk) begin
        cmd_seen <= cmd_seen | {abrx, txs, abt, brk};
        if (irq === 1'b1) irq_cnt++;
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask
    // one-cycle strobe; callers leave an edge before the next one
    task automatic strobe(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic sleep_req();
        c2_wd = 8'h08;
        strobe(c2_wr);
        tick(40);
    endtask

    initial begin
        tick(10);
        chk("run", 1, run);
        chk("creg1", 8'h00, creg1);
        i_rst = 1'b0;
        tick(1);
        foreach (rows[i]) begin
            cmd_seen = 4'h0;
            c1_wd = rows[i].wd;
            strobe(c1_wr);
            tick(40);
            chk("creg1", rows[i].rg, creg1);
            chk("cmds", rows[i].cmd, cmd_seen);
            chk("crc", !rows[i].wd[5], crc);
        end
        // a second write inside the window replaces the first
        cmd_seen = 4'h0;
        c1_wd = 8'h20;
        strobe(c1_wr);
        tick(4);
        c1_wd = 8'h08;
        strobe(c1_wr);
        tick(15);
        chk("creg1", 8'h00, creg1);
        tick(15);
        chk("crc", 1, crc);
        chk("cmds", 4'h4, cmd_seen);
        c1_wd = 8'h20;
        strobe(c1_wr);
        tick(22);
        chk("crc", 1, crc);
        tick(1);
        chk("crc", 1, crc);
        tick(1);
        chk("crc", 0, crc);
        // tx write overwritten inside busy window, pushed once
        tx_wd = 8'h11;
        strobe(tx_wr);
        tick(2);
        chk("wbusy", 1, st[ST_WBUSY]);
        tick(48);
        tx_wd = 8'h22;
        strobe(tx_wr);
        n = 0;
        while (push !== 1'b1 && n < 300) begin
            tick(1);
            n++;
        end
        chk("push_cyc", 190, n[7:0]);
        chk("txd", 8'h22, txd);
        tick(1);
        chk("wbusy", 0, st[ST_WBUSY]);
        // rx read hides fill bits for the read window
        lm_u.o_fill = 2'h2;
        lm_u.o_data = 8'hA5;
        strobe(rx_rd);
        chk("pop", 1, pop);
        tick(100);
        chk("fill", 0, st[7:6]);
        tick(90);
        chk("fill", 2, st[7:6]);
        chk("rxd", 8'hA5, rxd);
        // sleep request waits for idle bus
        lm_u.hold(1);
        irq_cnt = 0;
        sleep_req();
        chk("pend", 1, pend);
        chk("creg2", 8'h00, creg2);
        chk("irqs", 0, irq_cnt);
        lm_u.hold(0);
        tick(3);
        chk("src", SRC_SLEEP, st[5:4]);
        chk("slp", 1, slp);
        chk("pend", 0, pend);
        // frame while asleep: wake then completion, newer code wins
        irq_cnt = 0;
        lm_u.frame(0);
        tick(10);
        chk("irqs", 2, irq_cnt);
        chk("src", SRC_DONE, st[5:4]);
        chk("slp", 0, slp);
        // awake edge with enable low gives nothing
        ie = 1'b0;
        irq_cnt = 0;
        lm_u.rise();
        lm_u.frame(0);
        tick(8);
        chk("irqs", 0, irq_cnt);
        ie = 1'b1;
        lm_u.frame(1);
        tick(2);
        chk("src", SRC_ERR, st[5:4]);
        chk("run", 0, run);
        lm_u.frame(0);
        tick(4);
        chk("irqs", 1, irq_cnt);
        c1_wd = 8'h10;
        strobe(c1_wr);
        tick(40);
        chk("run", 1, run);
        // wake bit leaves sleep without a pulse
        sleep_req();
        chk("slp", 1, slp);
        irq_cnt = 0;
        c2_wd = 8'h01;
        strobe(c2_wr);
        tick(40);
        chk("slp", 0, slp);
        chk("src", SRC_WAKE, st[5:4]);
        chk("irqs", 0, irq_cnt);
        // stop: wake edge ignores enable, link waits for settle
        sleep_req();
        sel = 3'h1;
        stop = 1'b1;
        ie = 1'b0;
        irq_cnt = 0;
        lm_u.rise();
        chk("irqs", 1, irq_cnt);
        chk("src", SRC_WAKE, st[5:4]);
        chk("run", 0, run);
        stop = 1'b0;
        ie = 1'b1;
        tick(60);
        chk("run", 1, run);
        chk("slp", 0, slp);
        // reset in mid-run restores control state
        i_rst = 1'b1;
        tick(2);
        chk("crc", 1, crc);
        chk("creg1", 8'h00, creg1);
        i_rst = 1'b0;
        tick(2);
        print_verdict();
    end
endmodule // tb_top
